/* File: common/rate_link_pkg.sv */
// shared constants and types for the port rate policy and link config block
package rate_link_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int NUM_PORTS = 3;
    localparam int NUM_LINK_PORTS = 2;
    localparam int RATE_W = 12;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [NUM_PORTS-1:0][7:0] RATE_POL_OFF = {8'h3B, 8'h2B, 8'h1B};
    localparam logic [NUM_LINK_PORTS-1:0][7:0] LINK_OFF = {8'h2C, 8'h1C};
    localparam logic [7:0] LINK_RSVD_OFF = 8'h3C;
    localparam logic [1:0] NO_PORT = 2'h3;

    // ------------------------------------------------------------------
    // rate policy fields and reset value
    // ------------------------------------------------------------------
    localparam int RX_DIFF_BIT = 7;
    localparam int RX_LO_EN_BIT = 6;
    localparam int RX_HI_EN_BIT = 5;
    localparam int RX_LO_FC_BIT = 4;
    localparam int RX_HI_FC_BIT = 3;
    localparam int TX_DIFF_BIT = 2;
    localparam int TX_LO_EN_BIT = 1;
    localparam int TX_HI_EN_BIT = 0;
    localparam logic [7:0] RATE_POL_RESET = 8'h00;

    // ------------------------------------------------------------------
    // link config reset value (straps overwrite bits 7..4 after reset)
    // ------------------------------------------------------------------
    localparam logic [7:0] LINK_RESET = 8'h0F;

    // ------------------------------------------------------------------
    // management-interface phy registers
    // ------------------------------------------------------------------
    localparam logic [4:0] MII_CTRL_REG = 5'h00;
    localparam logic [4:0] MII_ADV_REG = 5'h04;
    localparam int MII_SPEED_BIT = 13;
    localparam int MII_AN_BIT = 12;
    localparam int MII_DUPLEX_BIT = 8;
    localparam int MII_PAUSE_BIT = 10;
    localparam int MII_100FD_BIT = 8;
    localparam int MII_100HD_BIT = 7;
    localparam int MII_10FD_BIT = 6;
    localparam int MII_10HD_BIT = 5;
    localparam logic [15:0] MII_SELECTOR = 16'h0001;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [RATE_W-1:0] rx_lo;
        logic [RATE_W-1:0] rx_hi;
        logic [RATE_W-1:0] tx_lo;
        logic [RATE_W-1:0] tx_hi;
    } rate_set_s;

    typedef struct packed {
        logic rx_lo_en;
        logic rx_hi_en;
        logic [RATE_W-1:0] rx_lo_rate;
        logic [RATE_W-1:0] rx_hi_rate;
        logic rx_lo_fc_en;
        logic rx_hi_fc_en;
        logic tx_shared;
        logic tx_lo_en;
        logic tx_hi_en;
        logic [RATE_W-1:0] tx_lo_rate;
        logic [RATE_W-1:0] tx_hi_rate;
    } policy_s;

    typedef struct packed {
        logic autoneg_en;
        logic speed_100;
        logic full_duplex;
        logic adv_pause;
        logic adv_100fd;
        logic adv_100hd;
        logic adv_10fd;
        logic adv_10hd;
    } link_cfg_s;

endpackage

/* File: hw/port_rate_link_regs.sv */
// per-port rate policy and phy link configuration registers
`timescale 1ns/1ps
// Behaviour
// - rx diff and low enable set: low priority frames limited at low rate
// - rx diff and high enable set: high priority frames limited at high rate
// - rx diff clear: every received frame limited at the low rate
// - low priority receive limiting is active only while bit 6 is set
// - diff clear, low enable set: all received frames use the low rate
// - bit 4 allows pause when the low receive rate is exceeded
// - bit 3 allows pause on high rate overrun, only with rx diff on
// - tx diff set: high and low frames limited by separate counters
// - tx diff clear: all transmitted frames share the low rate counter
// - low priority transmit limiting enabled only while bit 1 is one
// - high priority transmit limiting follows bit 0 with tx diff set, bit 1 with tx diff clear
// - one rate policy register per port at 0x1B, 0x2B and 0x3B
// - link bit 7 clear forces speed and duplex from bits 6 and 5
// - link bit 6 selects 100 Mb/s when set, 10 Mb/s when clear
// - link bit 5 selects full duplex, also as autonegotiation fallback
// - ports 1 and 2 take autoneg, speed, duplex reset values from straps
// - link bit 4 advertises pause; reset value comes from a strap
// - bits 3..0 advertise 100F, 100H, 10F, 10H, each resetting to one
// - port 3 has no link register; offset 0x3C is reserved
// - link registers are also reachable through phy regs 0 and 4
// - each rate is a 12-bit count of 32 kb/s blocks per second
module port_rate_link_regs import rate_link_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // straps
    input wire logic port1_autoneg_strap,
    input wire logic port2_autoneg_strap,
    input wire logic port1_speed_strap,
    input wire logic port2_speed_strap,
    input wire logic port1_duplex_strap,
    input wire logic port2_duplex_strap,
    input wire logic advertise_pause_strap,
    // byte register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_ff,
    output logic reg_rvalid_ff,
    // management-interface phy register port
    input wire logic miim_port,
    input wire logic [4:0] miim_reg,
    input wire logic miim_wr,
    input wire logic miim_rd,
    input wire logic [15:0] miim_wdata,
    output logic [15:0] miim_rdata_ff,
    output logic miim_rvalid_ff,
    // rate values from the rate registers
    input wire rate_set_s [NUM_PORTS-1:0] port_rates,
    // effective controls
    output policy_s [NUM_PORTS-1:0] policy_ff,
    output link_cfg_s [NUM_LINK_PORTS-1:0] link_ff
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic logic [1:0] rate_index(input logic [7:0] addr);
        logic [1:0] idx;
        idx = NO_PORT;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (addr == RATE_POL_OFF[i]) begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [1:0] link_index(input logic [7:0] addr);
        logic [1:0] idx;
        idx = NO_PORT;
        for (int i = 0; i < NUM_LINK_PORTS; i++) begin
            if (addr == LINK_OFF[i]) begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [15:0] mii_ctrl_word(input link_cfg_s c);
        logic [15:0] w;
        w = 16'h0000;
        w[MII_SPEED_BIT] = c.speed_100;
        w[MII_AN_BIT] = c.autoneg_en;
        w[MII_DUPLEX_BIT] = c.full_duplex;
        return w;
    endfunction

    function automatic logic [15:0] mii_adv_word(input link_cfg_s c);
        logic [15:0] w;
        w = MII_SELECTOR;
        w[MII_PAUSE_BIT] = c.adv_pause;
        w[MII_100FD_BIT] = c.adv_100fd;
        w[MII_100HD_BIT] = c.adv_100hd;
        w[MII_10FD_BIT] = c.adv_10fd;
        w[MII_10HD_BIT] = c.adv_10hd;
        return w;
    endfunction

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [NUM_PORTS-1:0][7:0] rate_pol_ff;
    logic [NUM_PORTS-1:0][7:0] nxt_rate_pol;
    link_cfg_s [NUM_LINK_PORTS-1:0] nxt_link;
    logic strap_pending_ff;
    logic nxt_strap_pending;
    logic [1:0] wr_rate_idx;
    logic [1:0] wr_link_idx;

    always_comb begin
        nxt_rate_pol = rate_pol_ff;
        nxt_link = link_ff;
        nxt_strap_pending = 1'b0;
        wr_rate_idx = rate_index(reg_addr);
        wr_link_idx = link_index(reg_addr);
        if (strap_pending_ff) begin
            // straps are caught on the first edge after reset release
            nxt_link[0].autoneg_en = port1_autoneg_strap;
            nxt_link[0].speed_100 = port1_speed_strap;
            nxt_link[0].full_duplex = port1_duplex_strap;
            nxt_link[1].autoneg_en = port2_autoneg_strap;
            nxt_link[1].speed_100 = port2_speed_strap;
            nxt_link[1].full_duplex = port2_duplex_strap;
            nxt_link[0].adv_pause = advertise_pause_strap;
            nxt_link[1].adv_pause = advertise_pause_strap;
        end else begin
            if (miim_wr && miim_reg == MII_CTRL_REG) begin
                nxt_link[miim_port].autoneg_en = miim_wdata[MII_AN_BIT];
                nxt_link[miim_port].speed_100 = miim_wdata[MII_SPEED_BIT];
                nxt_link[miim_port].full_duplex = miim_wdata[MII_DUPLEX_BIT];
            end
            if (miim_wr && miim_reg == MII_ADV_REG) begin
                nxt_link[miim_port].adv_pause = miim_wdata[MII_PAUSE_BIT];
                nxt_link[miim_port].adv_100fd = miim_wdata[MII_100FD_BIT];
                nxt_link[miim_port].adv_100hd = miim_wdata[MII_100HD_BIT];
                nxt_link[miim_port].adv_10fd = miim_wdata[MII_10FD_BIT];
                nxt_link[miim_port].adv_10hd = miim_wdata[MII_10HD_BIT];
            end
            // a byte write to the same register lands after the phy write
            if (reg_wr && wr_rate_idx != NO_PORT) begin
                nxt_rate_pol[wr_rate_idx] = reg_wdata;
            end
            if (reg_wr && wr_link_idx != NO_PORT) begin
                nxt_link[wr_link_idx] = reg_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rate_pol_ff <= {NUM_PORTS{RATE_POL_RESET}};
            link_ff <= {NUM_LINK_PORTS{LINK_RESET}};
            strap_pending_ff <= 1'b1;
        end else begin
            rate_pol_ff <= nxt_rate_pol;
            link_ff <= nxt_link;
            strap_pending_ff <= nxt_strap_pending;
        end
    end

    // ------------------------------------------------------------------
    // read paths, one cycle latency
    // ------------------------------------------------------------------
    logic [7:0] nxt_rdata;
    logic [15:0] nxt_miim_rdata;
    logic [1:0] rd_rate_idx;
    logic [1:0] rd_link_idx;

    always_comb begin
        rd_rate_idx = rate_index(reg_addr);
        rd_link_idx = link_index(reg_addr);
        nxt_rdata = 8'h00;
        // the reserved port 3 slot falls through and reads zero
        if (rd_rate_idx != NO_PORT) begin
            nxt_rdata = rate_pol_ff[rd_rate_idx];
        end else if (rd_link_idx != NO_PORT) begin
            nxt_rdata = link_ff[rd_link_idx];
        end
        nxt_miim_rdata = 16'h0000;
        if (miim_reg == MII_CTRL_REG) begin
            nxt_miim_rdata = mii_ctrl_word(link_ff[miim_port]);
        end else if (miim_reg == MII_ADV_REG) begin
            nxt_miim_rdata = mii_adv_word(link_ff[miim_port]);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_ff <= 8'h00;
            reg_rvalid_ff <= 1'b0;
            miim_rdata_ff <= 16'h0000;
            miim_rvalid_ff <= 1'b0;
        end else begin
            reg_rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
            reg_rvalid_ff <= reg_rd;
            miim_rdata_ff <= miim_rd ? nxt_miim_rdata : 16'h0000;
            miim_rvalid_ff <= miim_rd;
        end
    end

    // ------------------------------------------------------------------
    // effective limiter controls
    // ------------------------------------------------------------------
    // registered so the limiters never see a half-decoded byte write
    policy_s [NUM_PORTS-1:0] nxt_policy;

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        rate_policy_decode u_decode (
            .policy_reg(rate_pol_ff[p]),
            .rates(port_rates[p]),
            .policy(nxt_policy[p])
        );
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            policy_ff <= '0;
        end else begin
            policy_ff <= nxt_policy;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_chk
        sequence pol_write;
            reg_wr && !strap_pending_ff && reg_addr == RATE_POL_OFF[p];
        endsequence

        rate_write_a: assert property (pol_write |=>
            rate_pol_ff[p] == $past(reg_wdata))
            else $error("rate policy write not stored");
        rx_lo_a: assert property (rate_pol_ff[p][RX_LO_EN_BIT] |=>
            policy_ff[p].rx_lo_en &&
            policy_ff[p].rx_lo_rate == $past(port_rates[p].rx_lo))
            else $error("low receive limit not applied");
        rx_lo_off_a: assert property (
            !rate_pol_ff[p][RX_LO_EN_BIT] |=> !policy_ff[p].rx_lo_en)
            else $error("low receive limit active while disabled");
        rx_hi_a: assert property (rate_pol_ff[p][RX_DIFF_BIT] &&
            rate_pol_ff[p][RX_HI_EN_BIT] |=> policy_ff[p].rx_hi_en &&
            policy_ff[p].rx_hi_rate == $past(port_rates[p].rx_hi))
            else $error("high receive limit not applied");
        rx_shared_a: assert property (
            !rate_pol_ff[p][RX_DIFF_BIT] &&
            rate_pol_ff[p][RX_LO_EN_BIT] |=> policy_ff[p].rx_hi_en &&
            policy_ff[p].rx_hi_rate == $past(port_rates[p].rx_lo))
            else $error("shared receive rate not used");
        rx_fc_off_a: assert property (
            !rate_pol_ff[p][RX_LO_FC_BIT] &&
            !rate_pol_ff[p][RX_HI_FC_BIT] |=>
            !policy_ff[p].rx_lo_fc_en && !policy_ff[p].rx_hi_fc_en)
            else $error("pause enabled while both pause bits clear");
        rx_hi_fc_a: assert property (!rate_pol_ff[p][RX_DIFF_BIT] &&
            !rate_pol_ff[p][RX_LO_FC_BIT] |=> !policy_ff[p].rx_hi_fc_en)
            else $error("high pause used without receive diff");
        tx_shared_a: assert property (
            !rate_pol_ff[p][TX_DIFF_BIT] |=>
            policy_ff[p].tx_shared &&
            policy_ff[p].tx_hi_rate == $past(port_rates[p].tx_lo))
            else $error("transmit counter not shared");
        tx_split_a: assert property (rate_pol_ff[p][TX_DIFF_BIT] |=>
            !policy_ff[p].tx_shared &&
            policy_ff[p].tx_hi_en == $past(rate_pol_ff[p][TX_HI_EN_BIT]))
            else $error("transmit counters not split");
        tx_off_a: assert property (!rate_pol_ff[p][TX_LO_EN_BIT] &&
            !rate_pol_ff[p][TX_HI_EN_BIT] |=>
            !policy_ff[p].tx_lo_en && !policy_ff[p].tx_hi_en)
            else $error("transmit limit active while disabled");
    end

    strap_load_a: assert property (strap_pending_ff |=>
        link_ff[0][7:4] == {$past(port1_autoneg_strap),
        $past(port1_speed_strap), $past(port1_duplex_strap),
        $past(advertise_pause_strap)})
        else $error("straps not loaded into port 1 link config");
    reserved_rd_a: assert property (
        reg_rd && reg_addr == LINK_RSVD_OFF
        |=> reg_rvalid_ff && reg_rdata_ff == 8'h00)
        else $error("reserved link slot read non-zero");
    link_wr_a: assert property (reg_wr && !strap_pending_ff &&
        reg_addr == LINK_OFF[1] |=> link_ff[1] == $past(reg_wdata))
        else $error("link config write not stored");

    sequence miim_an_round_trip;
        miim_wr && !reg_wr && !strap_pending_ff && miim_reg == MII_CTRL_REG
        ##1 miim_rd && miim_reg == MII_CTRL_REG &&
        miim_port == $past(miim_port);
    endsequence

    miim_ctrl_a: assert property (miim_an_round_trip |=>
        miim_rvalid_ff &&
        miim_rdata_ff[MII_AN_BIT] == $past(miim_wdata[MII_AN_BIT], 2))
        else $error("phy control write not read back");

endmodule // port_rate_link_regs

/* File: hw/rate_policy_decode.sv */
// decodes one port's rate policy byte into effective limiter controls
`timescale 1ns/1ps
module rate_policy_decode import rate_link_pkg::*; (
    // policy byte and rate values
    input wire logic [7:0] policy_reg,
    input wire rate_set_s rates,
    // effective controls
    output policy_s policy
);

    always_comb begin
        policy.rx_lo_en = policy_reg[RX_LO_EN_BIT];
        policy.rx_lo_rate = rates.rx_lo;
        if (policy_reg[RX_DIFF_BIT]) begin
            policy.rx_hi_en = policy_reg[RX_HI_EN_BIT];
            policy.rx_hi_rate = rates.rx_hi;
            policy.rx_hi_fc_en = policy_reg[RX_HI_FC_BIT];
        end else begin
            // high priority traffic shares the low rate and its pause
            policy.rx_hi_en = policy_reg[RX_LO_EN_BIT];
            policy.rx_hi_rate = rates.rx_lo;
            policy.rx_hi_fc_en = policy_reg[RX_LO_FC_BIT];
        end
        policy.rx_lo_fc_en = policy_reg[RX_LO_FC_BIT];
        policy.tx_lo_en = policy_reg[TX_LO_EN_BIT];
        policy.tx_lo_rate = rates.tx_lo;
        policy.tx_shared = ~policy_reg[TX_DIFF_BIT];
        if (policy_reg[TX_DIFF_BIT]) begin
            policy.tx_hi_en = policy_reg[TX_HI_EN_BIT];
            policy.tx_hi_rate = rates.tx_hi;
        end else begin
            policy.tx_hi_en = policy_reg[TX_LO_EN_BIT];
            policy.tx_hi_rate = rates.tx_lo;
        end
    end

endmodule // rate_policy_decode

/* File: tb/port_rate_link_regs_tb_top.sv */
// self-checking bench for the port rate policy and link config registers
`timescale 1ns/1ps
module port_rate_link_regs_tb_top import rate_link_pkg::*; ;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic port1_autoneg_strap, port2_autoneg_strap;
    logic port1_speed_strap, port2_speed_strap;
    logic port1_duplex_strap, port2_duplex_strap, advertise_pause_strap;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_ff;
    logic reg_wr, reg_rd, reg_rvalid_ff;
    logic miim_port, miim_wr, miim_rd, miim_rvalid_ff;
    logic [4:0] miim_reg;
    logic [15:0] miim_wdata, miim_rdata_ff;
    rate_set_s [NUM_PORTS-1:0] port_rates;
    policy_s [NUM_PORTS-1:0] policy_ff;
    link_cfg_s [NUM_LINK_PORTS-1:0] link_ff;
    integer seed = 32'hb701;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [7:0] rate_m [NUM_PORTS];
    logic [7:0] link_m [NUM_LINK_PORTS];

    port_rate_link_regs DUT (
        .ref_clk, .resetn,
        .port1_autoneg_strap, .port2_autoneg_strap,
        .port1_speed_strap, .port2_speed_strap,
        .port1_duplex_strap, .port2_duplex_strap, .advertise_pause_strap,
        .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_ff, .reg_rvalid_ff,
        .miim_port, .miim_reg, .miim_wr, .miim_rd, .miim_wdata,
        .miim_rdata_ff, .miim_rvalid_ff,
        .port_rates, .policy_ff, .link_ff
    );

    always #10 ref_clk = ~ref_clk;

    // ------------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------------
    task automatic test_done();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // the full sweep needs about 1600 cycles, so this leaves ample margin
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkpol(input policy_s got, input policy_s exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ------------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------------
    function automatic policy_s pol_exp(input logic [7:0] b,
                                        input rate_set_s r);
        policy_s e;
        e.rx_lo_en = b[RX_LO_EN_BIT];
        e.rx_lo_rate = r.rx_lo;
        e.rx_lo_fc_en = b[RX_LO_FC_BIT];
        // diff off: high frames fall back to the low limiter and its pause
        e.rx_hi_en = b[7] ? b[5] : b[6];
        e.rx_hi_rate = b[7] ? r.rx_hi : r.rx_lo;
        e.rx_hi_fc_en = b[7] ? b[3] : b[4];
        e.tx_shared = ~b[TX_DIFF_BIT];
        e.tx_lo_en = b[TX_LO_EN_BIT];
        e.tx_hi_en = b[2] ? b[0] : b[1];
        e.tx_lo_rate = r.tx_lo;
        e.tx_hi_rate = b[2] ? r.tx_hi : r.tx_lo;
        return e;
    endfunction

    function automatic logic [15:0] mexp(input logic p, input logic [4:0] r);
        logic [15:0] e;
        logic [7:0] b;
        e = 16'h0000;
        b = link_m[p];
        if (r == MII_CTRL_REG) begin
            e[MII_AN_BIT] = b[7];
            e[MII_SPEED_BIT] = b[6];
            e[MII_DUPLEX_BIT] = b[5];
        end else if (r == MII_ADV_REG) begin
            e = MII_SELECTOR;
            e[MII_PAUSE_BIT] = b[4];
            e[MII_100FD_BIT] = b[3];
            e[MII_100HD_BIT] = b[2];
            e[MII_10FD_BIT] = b[1];
            e[MII_10HD_BIT] = b[0];
        end
        return e;
    endfunction

    function automatic rate_set_s rnd_rates();
        return rate_set_s'({$random(seed), 16'($random(seed))});
    endfunction

    // ------------------------------------------------------------------
    // bus tasks; all but the phy write end one idle cycle after the strobe
    // ------------------------------------------------------------------
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk); #1;
        reg_wr = 1'b0;
        @(posedge ref_clk); #1;
    endtask

    task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk); #1;
        reg_rd = 1'b0;
        chk8(8'(reg_rvalid_ff), 8'h01);
        chk8(reg_rdata_ff, exp);
        @(posedge ref_clk); #1;
        chk16({7'h00, reg_rdata_ff, reg_rvalid_ff}, 16'h0000);
    endtask

    task automatic mwr(input logic p, input logic [4:0] r,
                       input logic [15:0] d);
        miim_port = p;
        miim_reg = r;
        miim_wdata = d;
        miim_wr = 1'b1;
        if (r == MII_CTRL_REG) begin
            link_m[p][7:5] = {d[MII_AN_BIT], d[MII_SPEED_BIT], d[8]};
        end else if (r == MII_ADV_REG) begin
            link_m[p][4:0] = {d[MII_PAUSE_BIT], d[8:5]};
        end
        @(posedge ref_clk); #1;
        miim_wr = 1'b0;
    endtask

    task automatic mrd(input logic p, input logic [4:0] r);
        miim_port = p;
        miim_reg = r;
        miim_rd = 1'b1;
        @(posedge ref_clk); #1;
        miim_rd = 1'b0;
        chk8(8'(miim_rvalid_ff), 8'h01);
        chk16(miim_rdata_ff, mexp(p, r));
        @(posedge ref_clk); #1;
        chk16(miim_rdata_ff, 16'h0000);
        chk8(8'(miim_rvalid_ff), 8'h00);
    endtask

    // ------------------------------------------------------------------
    // reset with fresh straps; link_ff[0] and port 3 policy_ff are checked in reset, then every register byte
    // ------------------------------------------------------------------
    task automatic do_reset();
        resetn = 1'b0;
        {port1_autoneg_strap, port2_autoneg_strap, port1_speed_strap,
         port2_speed_strap, port1_duplex_strap, port2_duplex_strap,
         advertise_pause_strap} = 7'($random(seed));
        for (int i = 0; i < NUM_PORTS; i++) begin
            rate_m[i] = RATE_POL_RESET;
        end
        repeat (6) @(posedge ref_clk);
        #1;
        chk8(link_ff[0], LINK_RESET);
        chkpol(policy_ff[NUM_PORTS-1], policy_s'(0));
        resetn = 1'b1;
        @(posedge ref_clk); #1;
        link_m[0] = {port1_autoneg_strap, port1_speed_strap,
                     port1_duplex_strap, advertise_pause_strap, 4'hF};
        link_m[1] = {port2_autoneg_strap, port2_speed_strap,
                     port2_duplex_strap, advertise_pause_strap, 4'hF};
        for (int i = 0; i < NUM_PORTS; i++) begin
            rd8(RATE_POL_OFF[i], 8'h00);
        end
        for (int i = 0; i < NUM_LINK_PORTS; i++) begin
            chk8(link_ff[i], link_m[i]);
            rd8(LINK_OFF[i], link_m[i]);
        end
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        int q;
        logic p;
        logic [7:0] b;
        logic [15:0] d16;
        policy_s e;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h00000;
        {miim_port, miim_reg, miim_wr, miim_rd, miim_wdata} = 24'h000000;
        for (q = 0; q < NUM_PORTS; q++) begin
            port_rates[q] = rnd_rates();
        end
        do_reset();
        // port 3 link slot and an unmapped byte must stay dead
        wr8(LINK_RSVD_OFF, 8'hFF);
        rd8(LINK_RSVD_OFF, 8'h00);
        rd8(8'h50, 8'h00);
        // every policy byte, spread over the three ports
        for (int k = 0; k < 256; k++) begin
            q = k % NUM_PORTS;
            port_rates[q] = rnd_rates();
            wr8(RATE_POL_OFF[q], 8'(k));
            rate_m[q] = 8'(k);
            @(posedge ref_clk); #1;
            for (int i = 0; i < NUM_PORTS; i++) begin
                e = pol_exp(rate_m[i], port_rates[i]);
                chkpol(policy_ff[i], e);
            end
            rd8(RATE_POL_OFF[q], rate_m[q]);
        end
        // link bytes through both access paths
        repeat (32) begin
            p = 1'($random(seed));
            b = 8'($random(seed));
            d16 = 16'($random(seed));
            if (d16[0]) begin
                wr8(LINK_OFF[p], b);
                link_m[p] = b;
            end else begin
                mwr(p, b[0] ? MII_ADV_REG : MII_CTRL_REG, d16);
            end
            chk8(link_ff[p], link_m[p]);
            // a phy write is read back at once to cover back to back use
            mrd(p, MII_CTRL_REG);
            mrd(p, MII_ADV_REG);
            rd8(LINK_OFF[p], link_m[p]);
        end
        mrd(1'b0, 5'h01);
        // a second reset mid-run must clear every write and reload straps
        do_reset();
        test_done();
    end
endmodule // port_rate_link_regs_tb_top
